//--- rswc_params.svh
// Overview of operation
// - Reset on power-on, pin low, watchdog
// - Hold reset 18ms, or 500ms in LOW_FREQ_CRYSTAL_MODE
// - Program counter cleared to 000h on reset
// - All port pins become inputs on reset
// - Watchdog counter and prescaler cleared on reset
// - Oscillator runs or restarts on reset
// - Pin/watchdog reset clears timer option except interrupt flag
// - Only power-on clears the timer counter
// - Sleep stops oscillator, timers; watchdog cleared
// - Sleep during conversion keeps clocks running
// - Five wake sources; pin change, conversion and low voltage each with enable
// - Pin or watchdog wake does full reset
// - Other wakes resume at 0x8 or next
// - High-frequency crystal wake takes 2ms, LOW_FREQ_CRYSTAL_MODE takes 500ms
// - Oscillator settle: 32 clocks, 2ms+32, or 500ms with no clocks in LOW_FREQ_CRYSTAL_MODE
// - Conversion wake adds 15 ADC clock periods
// - Watchdog on, enables off: pin/watchdog only
// - Time-out/power-down flags record reset cause
// - Instructions update both flags, time-out only the time-out flag
// - Pin-change wake keeps control registers
`ifndef RSWC_PARAMS_SVH
`define RSWC_PARAMS_SVH
// Register indices; byte address is four times the index
`define RSWC_IDX_TMR_OPT 8'h01
`define RSWC_IDX_STATUS 8'h03
`define RSWC_IDX_WAKE 8'h0D
`define RSWC_IDX_WDT_CTL 8'h0E
`define RSWC_IDX_OSC_CFG 8'h10
// Field positions
`define RSWC_WDC_EN 7
`define RSWC_WDC_PSWE 5
`define RSWC_WDC_PSW_HI 4
`define RSWC_WDC_PSW_LO 2
`define RSWC_WUC_LOW_VOLTAGE_WAKE_EN 5
`define RSWC_WUC_PIN_CHANGE_WAKE_EN 4
`define RSWC_WUC_ADC_DONE_WAKE_EN 3
`define RSWC_TOP_INT 6
`define RSWC_ST_T 4
`define RSWC_ST_P 3
// Reset values and vectors
`define RSWC_WDC_RST 8'h00
`define RSWC_WUC_RST 8'h00
`define RSWC_TOP_RST 8'h00
`define RSWC_VEC_RESET 11'h000
`define RSWC_VEC_IRQ 11'h008
// Timing
`define RSWC_CLK_NS 8
`define RSWC_TICK_NS 1000
`define RSWC_TAD_NS 4000
`define RSWC_HOLD_US 18000
`define RSWC_HOLD_LXT_US 500000
`define RSWC_WAKE_HXT_US 2000
`define RSWC_WAKE_LXT_US 500000
`define RSWC_WDT_US 18000
`define RSWC_OSC_CLKS 32
`define RSWC_ADC_WAKE_TAD 15
`endif

//--- rswc_pkg.sv
package rswc_pkg;
   typedef enum logic [2:0] {
      ST_HOLD = 3'b000,
      ST_RUN = 3'b001,
      ST_SLEEP = 3'b010,
      ST_WAKE_MS = 3'b011,
      ST_WAKE_CLK = 3'b100
   } rswc_state_e;
   typedef enum logic [1:0] {
      OSC_RC = 2'b00,
      OSC_HXT = 2'b01,
      OSC_LXT = 2'b10
   } rswc_osc_e;
   // Single-cycle instruction strobes from the core
   typedef struct packed {
      logic sleep_instr;
      logic watchdog_clear_instr;
      logic global_irq_on_instr;
      logic global_irq_off_instr;
   } rswc_instr_s;
   // Wake event levels from peripherals
   typedef struct packed {
      logic pin_change;
      logic adc_done;
      logic low_voltage;
   } rswc_wake_s;
   // Clock run controls toward the oscillator and timers
   typedef struct packed {
      logic osc_run;
      logic timers_run;
   } rswc_run_s;
endpackage : rswc_pkg

//--- rswc_reset_sleep_wake_control.sv
`timescale 1ns/100ps
`include "rswc_params.svh"
module rswc_reset_sleep_wake_control
   import rswc_pkg::*;
#(
   parameter int CNT_W = 20,
   parameter int HOLD_TICKS = `RSWC_HOLD_US * 1000 / `RSWC_TICK_NS,
   parameter int HOLD_LXT_TICKS =
      `RSWC_HOLD_LXT_US * 1000 / `RSWC_TICK_NS,
   parameter int WAKE_HXT_TICKS =
      `RSWC_WAKE_HXT_US * 1000 / `RSWC_TICK_NS,
   parameter int WAKE_LXT_TICKS =
      `RSWC_WAKE_LXT_US * 1000 / `RSWC_TICK_NS,
   parameter int WDT_TICKS = `RSWC_WDT_US * 1000 / `RSWC_TICK_NS,
   parameter int ADC_WAKE_CLKS =
      `RSWC_ADC_WAKE_TAD * `RSWC_TAD_NS / `RSWC_CLK_NS
) (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic pready,
   output logic [31:0] prdata,
   output logic pslverr,
   input wire logic ext_reset_n,
   input wire logic wdt_tick,
   input wire logic adc_busy,
   input wire logic tcc_overflow,
   input wire rswc_instr_s instr,
   input wire rswc_wake_s wake,
   output logic core_reset,
   output logic pc_load,
   output logic [10:0] pc_vector,
   output logic resume_next,
   output logic ctrl_defaults,
   output logic tcc_clear,
   output logic sleeping,
   output rswc_run_s run_ctl
);
   localparam logic [15:0] OSC_CLKS = 16'(`RSWC_OSC_CLKS);
   localparam logic [15:0] ADC_CLKS = 16'(ADC_WAKE_CLKS);

   rswc_state_e state_q;
   logic [CNT_W-1:0] cnt_q;
   logic [15:0] ccnt_q;
   logic [15:0] clk_last_q;
   logic [CNT_W-1:0] wcnt_q;
   logic [7:0] presc_q;
   logic [7:0] wdc_q;
   logic [7:0] wuc_q;
   logic [7:0] top_q;
   logic [1:0] osc_cfg_q;
   logic flag_t_q;
   logic flag_p_q;
   logic gie_q;
   logic sleep_adc_q;
   logic pready_q;
   logic [31:0] prdata_q;
   logic pslverr_q;
   logic core_reset_q;
   logic pc_load_q;
   logic [10:0] pc_vector_q;
   logic resume_next_q;
   logic ctrl_defaults_q;
   logic tcc_clear_q;
   rswc_run_s run_q;

   logic pin_low;
   logic wdt_en;
   logic [7:0] presc_mask;
   logic wdt_step;
   logic wdt_timeout;
   logic full_rst;
   logic wake_any;
   logic running;
   logic [CNT_W-1:0] hold_last;
   logic [CNT_W-1:0] wake_ms_last;
   logic [15:0] clk_need;
   logic acc;
   logic wr_en;
   logic [7:0] idx;
   logic mapped;

   // Decode of reset causes; the pin is sampled as a synchronous level
   assign pin_low = ~ext_reset_n;
   assign wdt_en = wdc_q[`RSWC_WDC_EN];
   assign presc_mask = 8'((9'h002 << wdc_q[`RSWC_WDC_PSW_HI:
      `RSWC_WDC_PSW_LO]) - 9'h001);
   // Prescaled watchdog step on the RC tick
   assign wdt_step = wdt_tick & (~wdc_q[`RSWC_WDC_PSWE] |
      ((presc_q & presc_mask) == presc_mask));
   assign wdt_timeout = wdt_en & wdt_step &
      (wcnt_q == CNT_W'(WDT_TICKS - 1));
   assign full_rst = pin_low | wdt_timeout;
   assign running = (state_q == ST_RUN);
   // all enables clear leaves pin/watchdog only
   assign wake_any = (wake.pin_change & wuc_q[`RSWC_WUC_PIN_CHANGE_WAKE_EN]) |
      (wake.adc_done & wuc_q[`RSWC_WUC_ADC_DONE_WAKE_EN]) |
      (wake.low_voltage & wuc_q[`RSWC_WUC_LOW_VOLTAGE_WAKE_EN]);
   assign hold_last = (osc_cfg_q == OSC_LXT) ?
      CNT_W'(HOLD_LXT_TICKS - 1) : CNT_W'(HOLD_TICKS - 1);
   // millisecond part of the wake delay
   assign wake_ms_last = (osc_cfg_q == OSC_LXT) ?
      CNT_W'(WAKE_LXT_TICKS - 1) : CNT_W'(WAKE_HXT_TICKS - 1);
   assign clk_need = ((osc_cfg_q == OSC_LXT) ? 16'h0000 : OSC_CLKS) +
      (wake.adc_done & wuc_q[`RSWC_WUC_ADC_DONE_WAKE_EN] ? ADC_CLKS : 16'h0000);

   // Reset and wake sequencer; outputs are set on transitions
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         state_q <= ST_HOLD;
         cnt_q <= '0;
         ccnt_q <= 16'h0000;
         clk_last_q <= 16'h0000;
         sleep_adc_q <= 1'b0;
         core_reset_q <= 1'b1;
         pc_load_q <= 1'b1;
         pc_vector_q <= `RSWC_VEC_RESET;
         resume_next_q <= 1'b0;
         ctrl_defaults_q <= 1'b1;
         tcc_clear_q <= 1'b1;
         run_q <= 2'b11;
      end else begin
         pc_load_q <= 1'b0;
         resume_next_q <= 1'b0;
         ctrl_defaults_q <= 1'b0;
         // counter clear belongs to power-on only
         tcc_clear_q <= 1'b0;
         if (full_rst) begin
            // pin or watchdog restarts the hold
            state_q <= ST_HOLD;
            cnt_q <= '0;
            core_reset_q <= 1'b1;
            pc_load_q <= 1'b1;
            pc_vector_q <= `RSWC_VEC_RESET;
            ctrl_defaults_q <= 1'b1;
            // oscillator restarts if it was stopped
            run_q <= 2'b11;
         end else begin
            unique case (state_q)
               ST_HOLD: begin
                  if (wdt_tick) begin
                     if (cnt_q == hold_last) begin
                        state_q <= ST_RUN;
                        core_reset_q <= 1'b0;
                        cnt_q <= '0;
                     end else begin
                        cnt_q <= cnt_q + CNT_W'(1);
                     end
                  end
               end
               ST_RUN: begin
                  if (instr.sleep_instr) begin
                     state_q <= ST_SLEEP;
                     sleep_adc_q <= adc_busy;
                     run_q <= adc_busy ? 2'b11 : 2'b00;
                  end
               end
               ST_SLEEP: begin
                  if (wake_any) begin
                     // Oscillator restarts at once to settle
                     run_q.osc_run <= 1'b1;
                     cnt_q <= '0;
                     ccnt_q <= 16'h0000;
                     clk_last_q <= (clk_need == 16'h0000) ?
                        16'h0000 : clk_need - 16'h0001;
                     state_q <= (osc_cfg_q == OSC_RC) ?
                        ST_WAKE_CLK : ST_WAKE_MS;
                  end
               end
               ST_WAKE_MS: begin
                  if (wdt_tick) begin
                     if (cnt_q == wake_ms_last) begin
                        state_q <= ST_WAKE_CLK;
                        cnt_q <= '0;
                     end else begin
                        cnt_q <= cnt_q + CNT_W'(1);
                     end
                  end
               end
               ST_WAKE_CLK: begin
                  if (ccnt_q == clk_last_q) begin
                     state_q <= ST_RUN;
                     run_q <= 2'b11;
                     sleep_adc_q <= 1'b0;
                     if (gie_q) begin
                        pc_load_q <= 1'b1;
                        pc_vector_q <= `RSWC_VEC_IRQ;
                     end else begin
                        resume_next_q <= 1'b1;
                     end
                  end else begin
                     ccnt_q <= ccnt_q + 16'h0001;
                  end
               end
               default: begin
                  state_q <= ST_HOLD;
               end
            endcase
         end
      end
   end

   // Watchdog counter and prescaler, both on the RC tick
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         presc_q <= 8'h00;
         wcnt_q <= '0;
      end else if (full_rst || state_q == ST_HOLD) begin
         presc_q <= 8'h00;
         wcnt_q <= '0;
      end else if (running &&
         (instr.watchdog_clear_instr || instr.sleep_instr)) begin
         // sleep clears the watchdog, which keeps counting
         presc_q <= 8'h00;
         wcnt_q <= '0;
      end else if (wdt_en && wdt_tick) begin
         presc_q <= presc_q + 8'h01;
         if (wdt_step) begin
            wcnt_q <= wcnt_q + CNT_W'(1);
         end
      end
   end

   // Time-out and power-down flags; time-out wins over instructions
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         flag_t_q <= 1'b1;
         flag_p_q <= 1'b1;
      end else if (wdt_timeout) begin
         flag_t_q <= 1'b0;
      end else if (pin_low) begin
         // pin in sleep gives 1,0; in operation kept
         if (state_q == ST_SLEEP) begin
            flag_t_q <= 1'b1;
            flag_p_q <= 1'b0;
         end
      end else if (state_q == ST_SLEEP && wake_any) begin
         flag_t_q <= 1'b1;
         flag_p_q <= 1'b0;
      end else if (running && instr.sleep_instr) begin
         flag_t_q <= 1'b1;
         flag_p_q <= 1'b0;
      end else if (running && instr.watchdog_clear_instr) begin
         flag_t_q <= 1'b1;
         flag_p_q <= 1'b1;
      end
   end

   // Global interrupt enable as set by the core's instructions
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         gie_q <= 1'b0;
      end else if (full_rst) begin
         gie_q <= 1'b0;
      end else if (instr.global_irq_on_instr) begin
         gie_q <= 1'b1;
      end else if (instr.global_irq_off_instr) begin
         gie_q <= 1'b0;
      end
   end

   // APB slave: one wait state, write at the completing edge
   assign acc = psel & penable;
   assign wr_en = acc & pready_q & pwrite;
   assign idx = paddr[9:2];
   assign mapped = (paddr[11:10] == 2'b00) &&
      (idx == `RSWC_IDX_TMR_OPT || idx == `RSWC_IDX_STATUS ||
       idx == `RSWC_IDX_WAKE || idx == `RSWC_IDX_WDT_CTL ||
       idx == `RSWC_IDX_OSC_CFG);

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         pready_q <= 1'b0;
         prdata_q <= 32'h00000000;
         pslverr_q <= 1'b0;
      end else if (acc && !pready_q) begin
         pready_q <= 1'b1;
         pslverr_q <= ~mapped;
         prdata_q <= 32'h00000000;
         if (paddr[11:10] == 2'b00) begin
            unique case (idx)
               `RSWC_IDX_TMR_OPT: prdata_q[7:0] <= top_q;
               `RSWC_IDX_STATUS: begin
                  prdata_q[`RSWC_ST_T] <= flag_t_q;
                  prdata_q[`RSWC_ST_P] <= flag_p_q;
               end
               `RSWC_IDX_WAKE: prdata_q[7:0] <= wuc_q;
               `RSWC_IDX_WDT_CTL: prdata_q[7:0] <= wdc_q;
               `RSWC_IDX_OSC_CFG: prdata_q[1:0] <= osc_cfg_q;
               default: prdata_q <= 32'h00000000;
            endcase
         end
      end else begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
      end
   end

   // Control registers; pin-change wake never touches them
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         wdc_q <= `RSWC_WDC_RST;
         wuc_q <= `RSWC_WUC_RST;
      end else if (full_rst) begin
         // pin and watchdog resets restore defaults
         wdc_q <= `RSWC_WDC_RST;
         wuc_q <= `RSWC_WUC_RST;
      end else if (wr_en && paddr[11:10] == 2'b00) begin
         if (idx == `RSWC_IDX_WDT_CTL) begin
            wdc_q <= {pwdata[7:2], 2'b00};
         end
         if (idx == `RSWC_IDX_WAKE) begin
            wuc_q <= {2'b00, pwdata[5:3], 3'b000};
         end
      end
   end

   // Timer option: interrupt flag survives soft resets, set wins
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         top_q <= `RSWC_TOP_RST;
      end else begin
         if (full_rst) begin
            // all zero except the interrupt flag
            top_q <= `RSWC_TOP_RST | (top_q & 8'h40);
         end else if (wr_en && paddr[11:10] == 2'b00 &&
            idx == `RSWC_IDX_TMR_OPT) begin
            top_q <= pwdata[7:0];
         end
         if (tcc_overflow) begin
            top_q[`RSWC_TOP_INT] <= 1'b1;
         end
      end
   end

   // Oscillator mode only changes by software; power-on picks RC
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         osc_cfg_q <= OSC_RC;
      end else if (wr_en && paddr[11:10] == 2'b00 &&
         idx == `RSWC_IDX_OSC_CFG) begin
         osc_cfg_q <= pwdata[1:0];
      end
   end

   // Sleep indicator for the core and power logic
   logic sleeping_q;
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         sleeping_q <= 1'b0;
      end else begin
         sleeping_q <= (state_q == ST_SLEEP) & ~full_rst & ~wake_any;
      end
   end

   assign pready = pready_q;
   assign prdata = prdata_q;
   assign pslverr = pslverr_q;
   assign core_reset = core_reset_q;
   assign pc_load = pc_load_q;
   assign pc_vector = pc_vector_q;
   assign resume_next = resume_next_q;
   assign ctrl_defaults = ctrl_defaults_q;
   assign tcc_clear = tcc_clear_q;
   assign sleeping = sleeping_q;
   assign run_ctl = run_q;
endmodule : rswc_reset_sleep_wake_control

//--- rswc_far_model.sv
`timescale 1ns/100ps
module rswc_far_model #(
   parameter int TICK_CLKS = 4,
   parameter int CONV_CLKS = 20
) (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic conv_go,
   output logic wdt_tick,
   output logic adc_busy,
   output logic adc_done
);
   int tick_cnt = 0;
   int conv_cnt;
   // Watchdog RC runs free, through sleep and reset alike
   always_ff @(posedge clk_sys) begin
      tick_cnt <= (tick_cnt + 1) % TICK_CLKS;
      wdt_tick <= (tick_cnt == 0);
   end
   // Conversion: busy for a fixed stretch, then one done pulse
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         conv_cnt <= 0;
         adc_busy <= 1'b0;
         adc_done <= 1'b0;
      end else begin
         adc_done <= (conv_cnt == 1);
         adc_busy <= conv_go || conv_cnt > 1;
         if (conv_go) begin
            conv_cnt <= CONV_CLKS;
         end else if (conv_cnt != 0) begin
            conv_cnt <= conv_cnt - 1;
         end
      end
   end
endmodule : rswc_far_model

//--- rswc_properties.sv
`timescale 1ns/100ps
module rswc_checker
   import rswc_pkg::*;
(
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic psel,
   input wire logic penable,
   input wire logic [11:0] paddr,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic ext_reset_n,
   input wire logic adc_busy,
   input wire rswc_instr_s instr,
   input wire logic core_reset,
   input wire logic pc_load,
   input wire logic [10:0] pc_vector,
   input wire logic tcc_clear,
   input wire logic sleeping,
   input wire rswc_run_s run_ctl
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (reset);
   logic awake;
   // Core is running: out of reset and not asleep
   assign awake = !core_reset && !sleeping;
   // APB answers after one wait state, for one cycle
   apb_wait_a: assert property (psel && penable && !pready
      |=> pready ##1 !pready) else $error("apb answer timing wrong");
   unmapped_err_a: assert property (pready && paddr[9:2] == 8'h0F
      |-> pslverr) else $error("unmapped access not refused");
   pin_reset_a: assert property ($fell(ext_reset_n)
      |-> ##[1:3] core_reset) else $error("reset pin ignored");
   sleep_stop_a: assert property (instr.sleep_instr && awake
      && !adc_busy |=> run_ctl == 2'b00) else $error("clocks kept");
   sleep_conv_a: assert property (instr.sleep_instr && awake
      && adc_busy |=> run_ctl == 2'b11 [*2]) else $error("clocks cut");
   sleep_enter_a: assert property (instr.sleep_instr && awake
      |-> ##2 sleeping) else $error("sleep not entered");
   por_only_a: assert property (!$past(reset) |-> !tcc_clear)
      else $error("counter cleared without power-on");
   reset_vec_a: assert property (core_reset && pc_load
      |-> pc_vector == 11'h000) else $error("reset vector wrong");
   irq_vec_a: assert property (pc_load && !core_reset
      |-> pc_vector == 11'h008) else $error("wake vector wrong");
   wake_osc_a: assert property ($fell(sleeping)
      |-> run_ctl.osc_run) else $error("oscillator off after wake");
endmodule : rswc_checker
bind rswc_reset_sleep_wake_control rswc_checker i_rswc_checker (
   .clk_sys(clk_sys), .reset(reset), .psel(psel), .penable(penable),
   .paddr(paddr), .pready(pready), .pslverr(pslverr),
   .ext_reset_n(ext_reset_n), .adc_busy(adc_busy), .instr(instr),
   .core_reset(core_reset), .pc_load(pc_load), .pc_vector(pc_vector),
   .tcc_clear(tcc_clear), .sleeping(sleeping), .run_ctl(run_ctl)
);

//--- rswc_reset_sleep_wake_control_tb.sv
`timescale 1ns/100ps
module rswc_reset_sleep_wake_control_tb
   import rswc_pkg::*;
;
   localparam int TD = 4;
   localparam int HOLD = 20;
   localparam logic [32:0] ALL = 33'h1_FFFF_FFFF;
   localparam logic [32:0] STS = 33'h1_FFFF_FF18;
   localparam logic [3:0] I_SLEEP = 4'h8, I_WDCLR = 4'h4;
   localparam logic [3:0] I_GON = 4'h2, I_GOFF = 4'h1;
   logic clk_sys = 1'b0, reset = 1'b1;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000, prdata;
   logic pready, pslverr, ext_reset_n = 1'b1, tcc_overflow = 1'b0;
   logic wdt_tick, adc_busy, adc_done, conv_go = 1'b0;
   logic pin_chg = 1'b0, low_v = 1'b0;
   logic core_reset, pc_load, resume_next, ctrl_defaults, tcc_clear;
   logic sleeping;
   logic [10:0] pc_vector;
   logic [32:0] exp_q[$], msk_q[$], mk;
   logic [7:0] r;
   rswc_instr_s instr = '0;
   rswc_wake_s wake;
   rswc_run_s run_ctl;
   int err_count = 0, total_checks = 0, seed = 79448, n;
   assign wake = {pin_chg, adc_done, low_v};
   always #4 clk_sys = ~clk_sys;
   // LOW_FREQ_CRYSTAL_MODE lengths keep their defaults: no scenario runs that mode
   rswc_reset_sleep_wake_control #(.HOLD_TICKS(HOLD),
      .WAKE_HXT_TICKS(5), .WDT_TICKS(16),
      .ADC_WAKE_CLKS(10)) i_rswc_reset_sleep_wake_control (
      .clk_sys(clk_sys), .reset(reset), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
      .prdata(prdata), .pslverr(pslverr), .ext_reset_n(ext_reset_n),
      .wdt_tick(wdt_tick), .adc_busy(adc_busy),
      .tcc_overflow(tcc_overflow), .instr(instr), .wake(wake),
      .core_reset(core_reset), .pc_load(pc_load), .pc_vector(pc_vector),
      .resume_next(resume_next), .ctrl_defaults(ctrl_defaults),
      .tcc_clear(tcc_clear), .sleeping(sleeping), .run_ctl(run_ctl));
   rswc_far_model #(.TICK_CLKS(TD)) i_rswc_far_model (
      .clk_sys(clk_sys), .reset(reset), .conv_go(conv_go),
      .wdt_tick(wdt_tick), .adc_busy(adc_busy), .adc_done(adc_done));
   task automatic summarize;
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : summarize
   task automatic chk(input string nm, input logic [32:0] s, e);
      total_checks++;
      if (s !== e) begin
         err_count++;
         $display("mismatch %s expected %h seen %h", nm, e, s);
      end
   endtask : chk
   task automatic done(input string nm);
      $display("test %s done", nm);
   endtask : done
   function automatic logic hit(input int k);
      case (k)
         0: return core_reset === 1'b0;
         1: return pc_load === 1'b1;
         2: return resume_next === 1'b1;
         3: return core_reset === 1'b1;
         default: return adc_done === 1'b1;
      endcase
   endfunction : hit
   // Bounded wait; n ends as the number of edges waited
   task automatic wait_on(input int k, input int lim);
      n = 0;
      do begin
         @(posedge clk_sys);
         #1;
         n++;
      end while (!hit(k) && n < lim);
      if (!hit(k)) begin
         chk("wait", k, 33'h1_0000_0000);
         summarize();
      end
   endtask : wait_on
   // One APB transfer; held until pready is seen at an edge
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [7:0] d);
      int k;
      k = $random(seed);
      @(posedge clk_sys);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {k[31:8], d};
      @(posedge clk_sys);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge clk_sys);
         k++;
      end while (pready !== 1'b1 && k < 20);
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1) begin
         chk("apb timeout", 33'h0, 33'h1);
         summarize();
      end
   endtask : apb
   task automatic rd(input logic [11:0] a, input logic [32:0] e, m);
      exp_q.push_back(e);
      msk_q.push_back(m);
      apb(1'b0, a, 8'h00);
   endtask : rd
   task automatic pulse(input logic [3:0] v);
      @(posedge clk_sys);
      instr <= v;
      @(posedge clk_sys);
      instr <= 4'h0;
   endtask : pulse
   // Read answers are matched in order against the queued notes
   always @(posedge clk_sys) begin
      if (pready === 1'b1 && pwrite === 1'b0) begin
         if (exp_q.size() == 0) begin
            chk("unexpected read", 33'h0, 33'h1);
         end else begin
            mk = msk_q.pop_front();
            chk("read data", {pslverr, prdata} & mk, exp_q.pop_front());
         end
      end
   end
   initial begin
      repeat (5) @(posedge clk_sys);
      #1;
      chk("por out", {core_reset, ctrl_defaults, tcc_clear, run_ctl,
         pc_vector}, {5'h1F, 11'h000});
      @(posedge clk_sys);
      reset <= 1'b0;
      wait_on(0, 200);
      // Hold counted on watchdog ticks
      chk("hold", n >= HOLD*TD-TD-4 && n <= HOLD*TD+TD+4, 1'b1);
      done("power-on");
      rd(12'h038, 33'h0, ALL);
      rd(12'h004, 33'h0, ALL);
      rd(12'h034, 33'h0, ALL);
      rd(12'h00C, 33'h18, STS);
      rd(12'h03C, 33'h1_0000_0000, ALL);
      apb(1'b1, 12'h03C, 8'hFF);
      r = $random(seed);
      apb(1'b1, 12'h004, r);
      rd(12'h004, {25'h0, r}, ALL);
      @(posedge clk_sys);
      tcc_overflow <= 1'b1;
      @(posedge clk_sys);
      tcc_overflow <= 1'b0;
      rd(12'h004, {25'h0, r | 8'h40}, ALL);
      done("registers");
      // software order before a pin-change sleep
      apb(1'b1, 12'h038, 8'h00);
      pulse(I_WDCLR);
      pulse(I_GON);
      apb(1'b1, 12'h034, 8'h10);
      pulse(I_SLEEP);
      #1;
      chk("sleep clocks", run_ctl, 2'b00);
      rd(12'h00C, 33'h10, STS);
      @(posedge clk_sys);
      pin_chg <= 1'b1;
      @(posedge clk_sys);
      pin_chg <= 1'b0;
      wait_on(1, 100);
      chk("irq vector", pc_vector, 11'h008);
      chk("rc wake delay", n >= 30 && n <= 40, 1'b1);
      rd(12'h00C, 33'h10, STS);
      rd(12'h034, 33'h10, ALL);
      done("pin change wake");
      // watchdog stays off for a conversion wake
      pulse(I_GOFF);
      apb(1'b1, 12'h034, 8'h08);
      @(posedge clk_sys);
      conv_go <= 1'b1;
      @(posedge clk_sys);
      conv_go <= 1'b0;
      pulse(I_SLEEP);
      #1;
      chk("conv clocks", run_ctl, 2'b11);
      wait_on(4, 40);
      wait_on(2, 100);
      chk("adc wake delay", n >= 40 && n <= 50, 1'b1);
      apb(1'b1, 12'h034, 8'h20);
      pulse(I_SLEEP);
      @(posedge clk_sys);
      low_v <= 1'b1;
      @(posedge clk_sys);
      low_v <= 1'b0;
      wait_on(2, 100);
      // Crystal mode: tick-counted settle, then the 32 clocks
      apb(1'b1, 12'h040, 8'h01);
      rd(12'h040, 33'h1, ALL);
      pulse(I_SLEEP);
      @(posedge clk_sys);
      low_v <= 1'b1;
      @(posedge clk_sys);
      low_v <= 1'b0;
      wait_on(2, 150);
      chk("hxt wake delay", n >= 4*TD+33 && n <= 5*TD+32, 1'b1);
      apb(1'b1, 12'h040, 8'h00);
      done("adc and low voltage wake");
      // Enables off: stray wake events must not wake the core
      apb(1'b1, 12'h034, 8'h00);
      apb(1'b1, 12'h038, 8'h80);
      pulse(I_WDCLR);
      pulse(I_SLEEP);
      @(posedge clk_sys);
      pin_chg <= 1'b1;
      low_v <= 1'b1;
      repeat (4) @(posedge clk_sys);
      pin_chg <= 1'b0;
      low_v <= 1'b0;
      #1;
      chk("ignored wake", sleeping, 1'b1);
      wait_on(3, 120);
      wait_on(0, 200);
      rd(12'h00C, 33'h00, STS);
      rd(12'h038, 33'h0, ALL);
      rd(12'h004, 33'h40, ALL);
      done("watchdog wake");
      @(posedge clk_sys);
      ext_reset_n <= 1'b0;
      repeat (4) @(posedge clk_sys);
      #1;
      chk("pin reset", {core_reset, ctrl_defaults, tcc_clear}, 3'b110);
      @(posedge clk_sys);
      ext_reset_n <= 1'b1;
      wait_on(0, 200);
      rd(12'h00C, 33'h00, STS);
      pulse(I_WDCLR);
      rd(12'h00C, 33'h18, STS);
      pulse(I_SLEEP);
      @(posedge clk_sys);
      ext_reset_n <= 1'b0;
      repeat (2) @(posedge clk_sys);
      ext_reset_n <= 1'b1;
      wait_on(0, 200);
      rd(12'h00C, 33'h10, STS);
      done("pin reset");
      summarize();
   end
endmodule : rswc_reset_sleep_wake_control_tb
